/* File: inc/dacc_pkg.sv */
// package: constants and types of the converter controller
`default_nettype none
package dacc_pkg;
  localparam int SAMPLE_W = 10;
  localparam int ADDR_W = 8;
  localparam int DIV_W = 16;
  localparam int STARTUP_W = 8;
  localparam int WARM_W = STARTUP_W + 2;
  localparam int WARM_MUL = 2;
  localparam int SRC_N = 4;
  localparam int SRC_IDX_W = 2;
  localparam int TRIGGER_SOURCE_SELECT_W = 3;
  localparam logic [TRIGGER_SOURCE_SELECT_W-1:0] TRIGGER_SOURCE_SELECT_LAST = 3'h3;
  localparam int KEY_W = 24;
  localparam logic [KEY_W-1:0] PROT_KEY = 24'h444143;
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h04;
  localparam int BUF_DEPTH = 2;
  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic [DIV_W-1:0] trigger_divider;
    logic [STARTUP_W-1:0] warmup;
    logic [1:0] rsvd;
    logic word_mode;
    logic converter_on_bit;
    logic [TRIGGER_SOURCE_SELECT_W-1:0] trigger_source_select;
    logic outside_trigger_enable;
  } dacc_cfg_t;

  typedef struct packed {
    logic [KEY_W-1:0] protect_key_field;
    logic [6:0] rsvd;
    logic enable;
  } dacc_prot_t;

  typedef struct packed {
    logic [5:0] rsvd_hi;
    logic [SAMPLE_W-1:0] second;
    logic [5:0] rsvd_lo;
    logic [SAMPLE_W-1:0] first;
  } conversion_data_reg_t;

  typedef enum logic [1:0] {ST_OFF, ST_WARM, ST_RUN} dacc_conv_st_t;
endpackage
`default_nettype wire

/* File: inc/dacc_strm_if.sv */
// interface: valid/ready sample stream between controller parts
`timescale 1ns/1ns
`default_nettype none
interface dacc_strm_if;
  logic valid;
  logic ready;
  logic [dacc_pkg::SAMPLE_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: hdl/dacc_sync.sv */
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module dacc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } dacc_sync_st_t;
  dacc_sync_st_t s_q, s_d;
  logic [W-1:0] differ;

  assign differ = s_q.s2 ^ s_q.s3;
  assign q = s_q.o;

  always_comb begin
    s_d = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // a bit follows only once stages two and three agree
    s_d.o = (s_q.s2 & ~differ) | (s_q.o & differ);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  property p_sync_agree;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> (((s_q.o ^ $past(s_q.o)) & $past(differ)) == '0);
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("output moved on disagreeing stages"); // RULE_09
endmodule
`default_nettype wire

/* File: hdl/dacc_fifo.sv */
// module: parameterised sample fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dacc_fifo #(
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  dacc_strm_if.snk in_s,
  dacc_strm_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][dacc_pkg::SAMPLE_W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } dacc_fifo_st_t;
  dacc_fifo_st_t s_q, s_d;
  logic push;
  logic pop;

  assign in_s.ready = (s_q.cnt != CW'(DEPTH));
  assign out_s.valid = (s_q.cnt != '0);
  assign out_s.data = s_q.mem[s_q.rp];

  always_comb begin
    push = in_s.valid && in_s.ready;
    pop = out_s.valid && out_s.ready;
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_s.data;
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  property p_fifo_bound;
    @(posedge clk) disable iff (!rst_n)
      (s_q.cnt == CW'(DEPTH) && !pop) |=> (s_q.cnt == CW'(DEPTH) && !in_s.ready);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count left full without a pop"); // RULE_11
endmodule
`default_nettype wire

/* File: hdl/dacc_top.sv */
// module: digital-to-analog converter control logic
// Overview of operation
// [RULE_01] one analog output fed with 10-bit sample codes
// [RULE_02] pacing selectable between outside trigger pins and internal trigger
// [RULE_03] dma request line lets a dma channel feed samples
// [RULE_04] converter on bit of config register switches converter on and off
// [RULE_05] divider and warm-up counts run on the master clock
// [RULE_06] internal mode: start needs converter on, sample written, internal tick
// [RULE_07] internal trigger rate set by trigger divider field
// [RULE_08] software keeps conversion rate at or below 500 KHz
// [RULE_09] outside mode: each conversion waits for rising edge of selected source
// [RULE_10] clearing outside trigger enable returns to internal triggering
// [RULE_11] pending samples sit in a 4 half-word fifo
// [RULE_12] writes accepted while transmit ready; unconverted samples queue
// [RULE_13] transmit ready low when fifo full or write cannot be taken
// [RULE_14] writer never writes data while transmit ready is low
// [RULE_15] word mode field picks half-word or full-word data writes
// [RULE_16] half-word: one sample from bits 9:0 per write
// [RULE_17] full-word: bits 9:0 first, then bits 25:16
// [RULE_18] software programs the warm-up field
// [RULE_19] config writes discarded and flagged while protection enabled
// [RULE_20] violation sets error flag and logs cancelled write address
// [RULE_21] protection enable changes only with key 0x444143
// [RULE_22] warm-up lasts (field plus one) times two clocks
// [RULE_23] internal trigger period is divider times clock period
// [RULE_24] source 0 pin, 1 to 3 timer outputs, 4 to 6 none
// [RULE_25] soft reset bit returns controller to reset state
// [RULE_26] each start pops one fifo sample to the cell; none when empty
`timescale 1ns/1ns
`default_nettype none
module dacc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset_bit,
  input wire logic converter_config_reg_wr,
  input wire logic [31:0] converter_config_reg_wdata,
  input wire logic protect_mode_wr,
  input wire logic [31:0] protect_mode_wdata,
  input wire logic protect_status_rd,
  input wire logic conversion_data_reg_wr,
  input wire logic [31:0] conversion_data_reg_wdata,
  input wire logic trigger_input_pin,
  input wire logic [2:0] timer_wave_output,
  output logic transmit_ready_flag,
  output logic peripheral_dma_req,
  output logic [31:0] converter_config_reg_rdata,
  output logic protect_enable,
  output logic protect_error_flag,
  output logic [7:0] protect_violation_addr,
  output logic dac_on,
  output logic [9:0] dac_code,
  output logic dac_load
);
  typedef struct packed {
    dacc_pkg::dacc_cfg_t cfg;
    logic prot_en;
    logic prot_err;
    logic [dacc_pkg::ADDR_W-1:0] prot_addr;
    logic lo_v;
    logic [dacc_pkg::SAMPLE_W-1:0] lo;
    logic hi_v;
    logic [dacc_pkg::SAMPLE_W-1:0] hi;
    logic tx_ready;
    dacc_pkg::dacc_conv_st_t st;
    logic [dacc_pkg::WARM_W-1:0] warm_cnt;
    logic [dacc_pkg::WARM_W-1:0] warm_seen;
    logic [dacc_pkg::DIV_W-1:0] div_cnt;
    logic [dacc_pkg::SRC_N-1:0] src_prev;
    logic [dacc_pkg::SAMPLE_W-1:0] code;
    logic load;
  } dacc_top_st_t;

  dacc_top_st_t s_q, s_d;
  logic clr_n;
  logic [dacc_pkg::SRC_N-1:0] src_sync;
  logic [dacc_pkg::SRC_N-1:0] src_rise;
  logic [dacc_pkg::DIV_W:0] div_next;
  logic int_tick;
  logic ext_hit;
  logic trig_hit;
  logic start;
  dacc_pkg::conversion_data_reg_t cdr_w;
  dacc_pkg::dacc_prot_t prot_w;
  dacc_pkg::dacc_cfg_t cfg_w;

  dacc_strm_if stage_s ();
  dacc_strm_if fill_s ();
  dacc_strm_if drain_s ();

  // soft reset acts like the hardware reset on every register
  assign clr_n = rst_n & ~soft_reset_bit; // RULE_25

  dacc_sync #(
    .W(dacc_pkg::SRC_N)
  ) u_sync (
    .clk(clk),
    .rst_n(clr_n),
    .d({timer_wave_output, trigger_input_pin}),
    .q(src_sync)
  );

  // two-entry buffer absorbs a word write's pair of samples
  dacc_fifo #(
    .DEPTH(dacc_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_n(clr_n),
    .in_s(stage_s),
    .out_s(fill_s)
  );

  dacc_fifo #(
    .DEPTH(dacc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(clr_n),
    .in_s(fill_s),
    .out_s(drain_s)
  ); // RULE_11

  assign cdr_w = dacc_pkg::conversion_data_reg_t'(conversion_data_reg_wdata);
  assign prot_w = dacc_pkg::dacc_prot_t'(protect_mode_wdata);
  assign cfg_w = dacc_pkg::dacc_cfg_t'(converter_config_reg_wdata);

  assign stage_s.valid = s_q.lo_v;
  assign stage_s.data = s_q.lo;

  // internal tick every trigger_divider clocks of the master clock
  assign div_next = {1'b0, s_q.div_cnt} + 1'b1; // RULE_05
  assign int_tick = div_next >= {1'b0, s_q.cfg.trigger_divider}; // RULE_07 RULE_23

  // rising edge on the selected source; codes above the last are dead
  assign src_rise = src_sync & ~s_q.src_prev; // RULE_09
  assign ext_hit = (s_q.cfg.trigger_source_select <= dacc_pkg::TRIGGER_SOURCE_SELECT_LAST) &&
                   src_rise[s_q.cfg.trigger_source_select[dacc_pkg::SRC_IDX_W-1:0]]; // RULE_24

  // clearing outside mode falls straight back to the internal tick
  assign trig_hit = s_q.cfg.outside_trigger_enable ? ext_hit : int_tick; // RULE_02 RULE_10

  // conversion only when warmed up, triggered and a sample waits
  assign start = (s_q.st == dacc_pkg::ST_RUN) && trig_hit && drain_s.valid; // RULE_06 RULE_26
  assign drain_s.ready = start; // RULE_26

  always_comb begin
    s_d = s_q;
    s_d.load = 1'b0;
    s_d.src_prev = src_sync;

    // config write, cancelled and logged under protection
    if (protect_status_rd) begin
      s_d.prot_err = 1'b0;
      s_d.prot_addr = '0;
    end
    if (converter_config_reg_wr) begin
      if (s_q.prot_en) begin
        s_d.prot_err = 1'b1; // RULE_19
        s_d.prot_addr = dacc_pkg::CFG_OFFSET; // RULE_20
      end else begin
        s_d.cfg = cfg_w; // RULE_15
        s_d.cfg.rsvd = '0;
      end
    end
    if (protect_mode_wr && prot_w.protect_key_field == dacc_pkg::PROT_KEY) begin
      s_d.prot_en = prot_w.enable; // RULE_21
    end

    // staging: lo goes to the buffer first, hi follows
    if (s_q.lo_v && stage_s.ready) begin
      s_d.lo_v = s_q.hi_v;
      s_d.lo = s_q.hi;
      s_d.hi_v = 1'b0;
    end
    if (conversion_data_reg_wr) begin
      s_d.lo_v = 1'b1; // RULE_12
      s_d.lo = cdr_w.first; // RULE_16
      s_d.hi_v = s_q.cfg.word_mode; // RULE_17
      s_d.hi = cdr_w.second; // RULE_17
    end
    s_d.tx_ready = !s_d.lo_v && fill_s.ready; // RULE_13

    // warm-up and run sequencing
    unique case (s_q.st)
      dacc_pkg::ST_OFF: begin
        if (s_q.cfg.converter_on_bit) begin
          s_d.st = dacc_pkg::ST_WARM; // RULE_04
          s_d.warm_cnt = {1'b0, s_q.cfg.warmup, 1'b1}; // RULE_22
          s_d.warm_seen = '0;
        end
      end
      dacc_pkg::ST_WARM: begin
        s_d.warm_seen = s_q.warm_seen + 1'b1;
        if (!s_q.cfg.converter_on_bit) begin
          s_d.st = dacc_pkg::ST_OFF; // RULE_04
        end else if (s_q.warm_cnt == '0) begin
          s_d.st = dacc_pkg::ST_RUN;
        end else begin
          s_d.warm_cnt = s_q.warm_cnt - 1'b1; // RULE_05
        end
      end
      dacc_pkg::ST_RUN: begin
        if (!s_q.cfg.converter_on_bit) begin
          s_d.st = dacc_pkg::ST_OFF; // RULE_04
        end
      end
      default: begin
        s_d.st = dacc_pkg::ST_OFF;
      end
    endcase

    // divider runs only while internally paced and running
    if (s_q.st != dacc_pkg::ST_RUN || s_q.cfg.outside_trigger_enable || int_tick) begin
      s_d.div_cnt = '0;
    end else begin
      s_d.div_cnt = div_next[dacc_pkg::DIV_W-1:0]; // RULE_23
    end

    if (start) begin
      s_d.code = drain_s.data; // RULE_01
      s_d.load = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!clr_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign transmit_ready_flag = s_q.tx_ready;
  assign peripheral_dma_req = s_q.tx_ready; // RULE_03
  assign converter_config_reg_rdata = s_q.cfg;
  assign protect_enable = s_q.prot_en;
  assign protect_error_flag = s_q.prot_err;
  assign protect_violation_addr = s_q.prot_addr;
  assign dac_on = s_q.cfg.converter_on_bit;
  assign dac_code = s_q.code;
  assign dac_load = s_q.load;

  property p_full_drops_ready;
    @(posedge clk) disable iff (!clr_n)
      !fill_s.ready |=> !s_q.tx_ready;
  endproperty
  a_full_drops_ready: assert property (p_full_drops_ready) else $error("ready with fifo full"); // RULE_13

  property p_load_cause;
    @(posedge clk) disable iff (!clr_n)
      s_q.load |-> $past(s_q.st == dacc_pkg::ST_RUN && trig_hit && drain_s.valid);
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("conversion without cause"); // RULE_06

  property p_cfg_kept;
    @(posedge clk) disable iff (!clr_n)
      (converter_config_reg_wr && s_q.prot_en) |=> $stable(s_q.cfg);
  endproperty
  a_cfg_kept: assert property (p_cfg_kept) else $error("protected config changed"); // RULE_19

  property p_err_logged;
    @(posedge clk) disable iff (!clr_n)
      (converter_config_reg_wr && s_q.prot_en) |=>
        (s_q.prot_err && s_q.prot_addr == dacc_pkg::CFG_OFFSET) ##1
        ($past(protect_status_rd) || (s_q.prot_err && s_q.prot_addr == dacc_pkg::CFG_OFFSET));
  endproperty
  a_err_logged: assert property (p_err_logged) else $error("violation not logged"); // RULE_20

  property p_bad_key;
    @(posedge clk) disable iff (!clr_n)
      (protect_mode_wr && prot_w.protect_key_field != dacc_pkg::PROT_KEY) |=>
        $stable(s_q.prot_en);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("protection changed by bad key"); // RULE_21

  property p_word_pair;
    @(posedge clk) disable iff (!clr_n)
      (conversion_data_reg_wr && s_q.tx_ready && s_q.cfg.word_mode) |=>
        s_q.lo_v && s_q.hi_v && s_q.hi == $past(cdr_w.second) && s_q.lo == $past(cdr_w.first);
  endproperty
  a_word_pair: assert property (p_word_pair) else $error("word write not split"); // RULE_17

  property p_warm_len;
    @(posedge clk) disable iff (!clr_n)
      (s_q.st == dacc_pkg::ST_RUN && $past(s_q.st) == dacc_pkg::ST_WARM) |->
        (32'($past(s_q.warm_seen)) + 1 ==
         (32'($past(s_q.cfg.warmup)) + 1) * dacc_pkg::WARM_MUL);
  endproperty
  a_warm_len: assert property (p_warm_len) else $error("warm-up length wrong"); // RULE_22
endmodule
`default_nettype wire

/* File: verif/dacc_wr_model.sv */
// dma-style sample writer model that feeds the controller data port
`timescale 1ns/1ns
`default_nettype none
module dacc_wr_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ready,
  input wire logic slow,
  output logic wr,
  output logic [31:0] wdata
);
  logic [31:0] q[$];
  logic pend;
  int gap;
  initial begin
    pend = 1'h0;
    wdata = 32'h0;
    gap = 0;
  end
  // strobe stands only while the ready flag is up at the taking edge
  assign wr = pend && ready;
  always @(posedge clk) begin
    if (!rst_n) begin
      pend <= 1'h0;
      gap <= 0;
    end else if (wr) begin
      // word taken at this edge; the next one waits out the gap
      pend <= 1'h0;
      void'(q.pop_front());
      gap <= slow ? 3 : 0;
    end else if (gap > 0) begin
      gap <= gap - 1;
    end else if (!pend && q.size() > 0) begin
      pend <= 1'h1;
      wdata <= q[0];
    end
  end
endmodule
`default_nettype wire

/* File: verif/dacc_top_bench.sv */
// self-checking bench for the converter controller
`timescale 1ns/1ns
`default_nettype none
module dacc_top_bench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic soft_rst = 1'h0;
  logic cfg_wr = 1'h0;
  logic prot_wr = 1'h0;
  logic st_rd = 1'h0;
  logic pin = 1'h0;
  logic slow = 1'h0;
  logic [2:0] tmr = 3'h0;
  logic [31:0] cfg_wd = 32'h0;
  logic [31:0] prot_wd = 32'h0;
  logic [31:0] last_cfg = 32'h0;
  logic d_wr, rdy, dreq, p_en, p_err, dac_on, dac_load;
  logic [31:0] d_wd, cfg_rd;
  logic [7:0] p_addr;
  logic [9:0] dac_code;
  logic [9:0] got[$], exp_q[$];
  int tld[$];
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int t_cfg, d3;

  dacc_top dut (
    .clk(clk), .rst_n(rst_n), .soft_reset_bit(soft_rst),
    .converter_config_reg_wr(cfg_wr), .converter_config_reg_wdata(cfg_wd),
    .protect_mode_wr(prot_wr), .protect_mode_wdata(prot_wd), .protect_status_rd(st_rd),
    .conversion_data_reg_wr(d_wr), .conversion_data_reg_wdata(d_wd),
    .trigger_input_pin(pin), .timer_wave_output(tmr), .transmit_ready_flag(rdy),
    .peripheral_dma_req(dreq), .converter_config_reg_rdata(cfg_rd), .protect_enable(p_en),
    .protect_error_flag(p_err), .protect_violation_addr(p_addr), .dac_on(dac_on),
    .dac_code(dac_code), .dac_load(dac_load)
  );
  dacc_wr_model wrm (
    .clk(clk), .rst_n(rst_n), .ready(dreq), .slow(slow), .wr(d_wr), .wdata(d_wd)
  );

  always #5 clk = ~clk;
  // record every converted code and the cycle it appeared in
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dac_load === 1'h1) begin
      got.push_back(dac_code);
      tld.push_back(cyc);
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait for n codes, or for the writer queue to empty
  task automatic wt(input int n, input int lim, input bit drain);
    int k;
    k = 0;
    while ((drain ? wrm.q.size() > 0 : got.size() < n) && k < lim) begin
      @(posedge clk);
      k++;
    end
    cyc_n(8);
    if (k >= lim) begin
      n_errors++;
      $display("Error at %0t: wait ran out", $time);
      results();
    end
  endtask
  task automatic cfg(input logic [15:0] dv, input logic [7:0] wu, input logic [5:0] lo,
                     input logic ok);
    @(posedge clk);
    cfg_wr <= 1'h1;
    cfg_wd <= {dv, wu, 2'h3, lo};
    @(posedge clk);
    cfg_wr <= 1'h0;
    #1;
    t_cfg = cyc;
    if (ok) last_cfg = {dv, wu, 2'h0, lo};
    chk(cfg_rd, last_cfg);
  endtask
  task automatic prot(input logic [23:0] key, input logic en);
    @(posedge clk);
    prot_wr <= 1'h1;
    prot_wd <= {key, 7'h0, en};
    @(posedge clk);
    prot_wr <= 1'h0;
    #1;
  endtask
  task automatic push(input int n, input logic [9:0] b, input logic w);
    logic [9:0] v;
    for (int i = 0; i < n; i++) begin
      v = b + 10'(2 * i);
      if (w) begin
        wrm.q.push_back({6'h3F, v + 10'h1, 6'h3F, v});
        exp_q.push_back(v);
        exp_q.push_back(v + 10'h1);
      end else begin
        wrm.q.push_back({22'h3FFFFF, v});
        exp_q.push_back(v);
      end
    end
  endtask
  task automatic cmp_codes(input string name);
    chk(got.size(), exp_q.size());
    while (got.size() > 0 && exp_q.size() > 0) chk(got.pop_front(), exp_q.pop_front());
    got.delete();
    exp_q.delete();
    tld.delete();
    $display("test %s done", name);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk(rdy, 1'h0);
    chk(cfg_rd, 32'h0);
    cyc_n(1);
    chk(rdy, 1'h1);
    chk(dreq, rdy);
    // warm-up: nothing converts while off; start delay grows by two cycles per step
    cfg(16'h0001, 8'h03, 6'h00, 1'h1);
    push(1, 10'h155, 1'h0);
    wt(0, 100, 1'h1);
    cyc_n(20);
    chk(got.size(), 0);
    cfg(16'h0001, 8'h03, 6'h10, 1'h1);
    wt(1, 200, 1'h0);
    chk(dac_on, 1'h1);
    d3 = tld[0] - t_cfg;
    chk(d3 >= 8 && d3 <= 12, 1'h1);
    cmp_codes("warm3");
    cfg(16'h0001, 8'h07, 6'h00, 1'h1);
    push(1, 10'h2AA, 1'h0);
    wt(0, 100, 1'h1);
    cfg(16'h0001, 8'h07, 6'h10, 1'h1);
    wt(1, 200, 1'h0);
    chk(tld[0] - t_cfg - d3, 8);
    cmp_codes("warm7");
    // internal divider, rate kept at or below 500 KHz
    for (int j = 0; j < 2; j++) begin
      cfg(j ? 16'h00FA : 16'h00C8, 8'h00, 6'h00, 1'h1);
      push(4, 10'h040 + 10'(j * 16), 1'h0);
      wt(0, 200, 1'h1);
      cfg(j ? 16'h00FA : 16'h00C8, 8'h00, 6'h10, 1'h1);
      wt(4, 1500, 1'h0);
      for (int i = 1; i < 4; i++) chk(tld[i] - tld[i - 1], j ? 250 : 200);
      cmp_codes("divider");
    end
    // word width packs two samples per write
    cfg(16'h00C8, 8'h00, 6'h20, 1'h1);
    push(3, 10'h100, 1'h1);
    wt(0, 200, 1'h1);
    cfg(16'h00C8, 8'h00, 6'h30, 1'h1);
    wt(6, 2000, 1'h0);
    cmp_codes("word");
    // fill until refused with a slow writer, then drain with nothing lost
    slow <= 1'h1;
    cfg(16'h00C8, 8'h00, 6'h00, 1'h1);
    push(10, 10'h300, 1'h0);
    cyc_n(80);
    chk(rdy, 1'h0);
    chk(dreq, rdy);
    chk(wrm.q.size() > 0, 1'h1);
    cfg(16'h00C8, 8'h00, 6'h10, 1'h1);
    wt(10, 3000, 1'h0);
    cmp_codes("full");
    slow <= 1'h0;
    // outside trigger per source code, reserved code never fires
    cfg(16'h00C8, 8'h00, 6'h00, 1'h1);
    push(5, 10'h050, 1'h0);
    wt(0, 200, 1'h1);
    for (int s = 0; s < 5; s++) begin
      cfg(16'h00C8, 8'h00, {2'h1, 3'(s), 1'h1}, 1'h1);
      cyc_n(30);
      chk(got.size(), s);
      if (s == 0 || s == 4) pin <= 1'h1;
      if (s > 0) tmr <= (s == 4) ? 3'h7 : 3'(1 << (s - 1));
      cyc_n(8);
      pin <= 1'h0;
      tmr <= 3'h0;
      cyc_n(20);
      chk(got.size(), s < 4 ? s + 1 : 4);
    end
    cfg(16'h00C8, 8'h00, 6'h10, 1'h1);
    wt(5, 1000, 1'h0);
    cmp_codes("trigger");
    // write protection with key, violation log and status clear
    prot(24'h123456, 1'h1);
    chk(p_en, 1'h0);
    prot(dacc_pkg::PROT_KEY, 1'h1);
    chk(p_en, 1'h1);
    cfg(16'h00C8, 8'h05, 6'h01, 1'h0);
    chk(p_err, 1'h1);
    chk(p_addr, dacc_pkg::CFG_OFFSET);
    @(posedge clk);
    st_rd <= 1'h1;
    @(posedge clk);
    st_rd <= 1'h0;
    cyc_n(1);
    chk(p_err, 1'h0);
    chk(p_addr, 8'h00);
    prot(24'h000000, 1'h0);
    chk(p_en, 1'h1);
    prot(dacc_pkg::PROT_KEY, 1'h0);
    chk(p_en, 1'h0);
    cfg(16'h00C8, 8'h00, 6'h00, 1'h1);
    $display("test protect done");
    // soft reset clears config, protection and queued samples
    push(2, 10'h222, 1'h0);
    wt(0, 200, 1'h1);
    prot(dacc_pkg::PROT_KEY, 1'h1);
    @(posedge clk);
    soft_rst <= 1'h1;
    @(posedge clk);
    soft_rst <= 1'h0;
    #1;
    chk(cfg_rd, 32'h0);
    chk(p_en, 1'h0);
    chk(dac_on, 1'h0);
    chk(rdy, 1'h0);
    cyc_n(1);
    chk(rdy, 1'h1);
    exp_q.delete();
    last_cfg = 32'h0;
    cfg(16'h00C8, 8'h00, 6'h10, 1'h1);
    cyc_n(600);
    cmp_codes("softreset");
    results();
  end
endmodule
`default_nettype wire
